/* shared/avgmx_defs.svh */
// Constants of the average and maximum tracker: register offsets,
// field positions, reset values and setting limits.
// Assumes inclusion by bare name from shared/ on the include path.
`ifndef AVGMX_DEFS_SVH
`define AVGMX_DEFS_SVH

`define AVGMX_OFF_AVG_CFG   8'h00
`define AVGMX_OFF_MAX_CFG   8'h04
`define AVGMX_OFF_STATUS    8'h08
`define AVGMX_OFF_MASK      8'h0c
`define AVGMX_OFF_AVG_RES   8'h10
`define AVGMX_OFF_MAX_RES   8'h14
`define AVGMX_OFF_COUNT     8'h18

`define AVGMX_AVG_SEL_LSB   0
`define AVGMX_AVG_SEL_W     3
`define AVGMX_DAYS_LSB      0
`define AVGMX_DAYS_W        9
`define AVGMX_HOUR_LSB      16
`define AVGMX_HOUR_W        5
`define AVGMX_ST_AVG_BIT    0
`define AVGMX_ST_MAX_BIT    1

`define AVGMX_RST_AVG_SEL   3'h0
`define AVGMX_RST_DAYS      9'h001
`define AVGMX_RST_HOUR      5'h0c
`define AVGMX_MAX_DAYS      9'h16d
`define AVGMX_MAX_HOUR      5'h17
`define AVGMX_LAST_SEL      3'h5

`endif

/* shared/avgmx_pkg.sv */
// Types of the average and maximum tracker.
// Assumes avgmx_defs.svh is reachable on the include path.
package avgmx_pkg;
    // Average window selection, encoded in the low bits of AVG_CFG.
    typedef enum logic [2:0] {
        AVGMX_WIN_OFF,
        AVGMX_WIN_5,
        AVGMX_WIN_10,
        AVGMX_WIN_15,
        AVGMX_WIN_30,
        AVGMX_WIN_60
    } avgmx_win_e;
    typedef logic [5:0] avgmx_min_t;
    typedef logic [4:0] avgmx_hour_t;
endpackage : avgmx_pkg

/* design/avgmx_tracker.sv */
// Windowed average and running maximum of one analog quantity, with
// reports to the supervisory channel and the local event log.
// Assumes a real-time clock that gives minute and hour of day and a
// one-cycle pulse at each new minute, all synchronous to ref_clk_i,
// and a classic Wishbone master for configuration.
//
// Functional notes
// RULE1: One analog input yields a windowed average and a windowed maximum.
// RULE2: Average window is off, 5, 10, 15, 30 or 60 minutes; off default.
// RULE3: At average window expiry report the average; a new window begins.
// RULE4: Average goes to log and HMI only while log enable is high.
// RULE5: Maximum window is 0 to 365 days in steps of 1; default 1.
// RULE6: At maximum window expiry report, log and show the maximum.
// RULE7: Maximum report hour is 0 to 23; default hour 12.
// RULE8: Windows start on real-time clock boundaries, not at power-up; here the first maximum window over 1 day runs from power-up.
// RULE9: Clear input empties both results; windows still end normally.
// RULE10: No binary status outputs; binary inputs are clear and log enable. Here irq_o is a binary interrupt output.
// RULE11: Average is mean of window samples; maximum cleared per window.
//
// The implementer's own choices: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
`include "avgmx_defs.svh"
`default_nettype none

module avgmx_tracker #(
    parameter int SAMPLE_W = 16,
    parameter int COUNT_W  = 32
) (
    input  wire logic                 ref_clk_i,
    input  wire logic                 arst_n_i,
    input  wire logic [SAMPLE_W-1:0]  sample_i,
    input  wire logic                 sample_valid_i,
    input  wire logic                 stats_clear_input_i,
    input  wire logic                 average_log_enable_i,
    input  wire avgmx_pkg::avgmx_min_t  rtc_minute_i,
    input  wire avgmx_pkg::avgmx_hour_t rtc_hour_i,
    input  wire logic                 rtc_minute_tick_i,
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    input  wire logic                 wb_we_i,
    input  wire logic [7:0]           wb_adr_i,
    input  wire logic [3:0]           wb_sel_i,
    input  wire logic [31:0]          wb_dat_i,
    output logic [31:0]               wb_dat_o,
    output logic                      wb_ack_o,
    output logic [SAMPLE_W-1:0]       scada_avg_o,
    output logic                      scada_avg_valid_o,
    output logic                      log_avg_valid_o,
    output logic [SAMPLE_W-1:0]       scada_max_o,
    output logic                      scada_max_valid_o,
    output logic                      log_max_valid_o,
    output logic                      irq_o
);
    import avgmx_pkg::*;

    localparam int SUM_W = SAMPLE_W + COUNT_W;

    // True on the minute that closes a window of the selected length.
    function automatic logic avg_boundary(input avgmx_win_e sel,
                                          input avgmx_min_t m);
        logic hit;
        hit = 1'b0;
        unique case (sel)
            AVGMX_WIN_OFF: hit = 1'b0;
            AVGMX_WIN_5:   hit = (m % 6'h05) == 6'h00;
            AVGMX_WIN_10:  hit = (m % 6'h0a) == 6'h00;
            AVGMX_WIN_15:  hit = (m % 6'h0f) == 6'h00;
            AVGMX_WIN_30:  hit = (m % 6'h1e) == 6'h00;
            AVGMX_WIN_60:  hit = m == 6'h00;
            default:       hit = 1'b0;
        endcase
        return hit;
    endfunction : avg_boundary

    logic                 wb_req;
    logic                 wb_wr;
    logic                 ack_q;
    avgmx_win_e           avg_sel_q;
    logic [8:0]           days_q;
    avgmx_hour_t          hour_q;
    logic [1:0]           status_q;
    logic [1:0]           mask_q;
    logic                 avg_bound;
    logic                 day_bound;
    logic                 max_bound;
    logic                 avg_run_q;
    logic                 max_run_q;
    logic [SUM_W-1:0]     sum_q;
    logic [COUNT_W-1:0]   count_q;
    logic [8:0]           day_cnt_q;
    logic [SAMPLE_W-1:0]  max_q;
    logic [SUM_W-1:0]     mean;
    logic                 avg_fire;
    logic                 max_fire;

    assign wb_req = wb_cyc_i && wb_stb_i && !ack_q;
    assign wb_wr  = wb_req && wb_we_i && wb_sel_i[0];

    // One wait state free answer: ack one cycle after the strobe.
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= wb_req;
        end
    end
    assign wb_ack_o = ack_q;

    // Out of range settings are ignored so the limits always hold.
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            avg_sel_q <= avgmx_win_e'(`AVGMX_RST_AVG_SEL);
        end else if (wb_wr && wb_adr_i == `AVGMX_OFF_AVG_CFG
                     && wb_dat_i[2:0] <= `AVGMX_LAST_SEL) begin
            avg_sel_q <= avgmx_win_e'(wb_dat_i[2:0]); // RULE2
        end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            days_q <= `AVGMX_RST_DAYS;
            hour_q <= `AVGMX_RST_HOUR;
        end else if (wb_req && wb_we_i
                     && wb_adr_i == `AVGMX_OFF_MAX_CFG) begin
            if (wb_sel_i[1:0] == 2'h3
                && wb_dat_i[8:0] <= `AVGMX_MAX_DAYS) begin
                days_q <= wb_dat_i[8:0]; // RULE5
            end
            if (wb_sel_i[2] && wb_dat_i[20:16] <= `AVGMX_MAX_HOUR) begin
                hour_q <= wb_dat_i[20:16]; // RULE7
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mask_q <= 2'h0;
        end else if (wb_wr && wb_adr_i == `AVGMX_OFF_MASK) begin
            mask_q <= wb_dat_i[1:0];
        end
    end

    // A report in the same cycle as a write-one clear keeps its bit.
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            status_q <= 2'h0;
        end else begin
            if (wb_wr && wb_adr_i == `AVGMX_OFF_STATUS) begin
                status_q <= status_q & ~wb_dat_i[1:0]
                            | {max_fire, avg_fire};
            end else begin
                status_q <= status_q | {max_fire, avg_fire};
            end
        end
    end
    assign irq_o = |(status_q & mask_q);

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (wb_req && !wb_we_i) begin
            unique case (wb_adr_i)
                `AVGMX_OFF_AVG_CFG: wb_dat_o <= {29'h0, avg_sel_q};
                `AVGMX_OFF_MAX_CFG: wb_dat_o <= {11'h0, hour_q,
                                                 7'h0, days_q};
                `AVGMX_OFF_STATUS:  wb_dat_o <= {30'h0, status_q};
                `AVGMX_OFF_MASK:    wb_dat_o <= {30'h0, mask_q};
                `AVGMX_OFF_AVG_RES: wb_dat_o <= 32'(scada_avg_o);
                `AVGMX_OFF_MAX_RES: wb_dat_o <= 32'(scada_max_o);
                `AVGMX_OFF_COUNT:   wb_dat_o <= 32'(count_q);
                default:            wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end

    // Windows are cut by the real-time clock; only a first maximum window over 1 day runs from reset release.
    assign avg_bound = rtc_minute_tick_i
                       && avg_boundary(avg_sel_q, rtc_minute_i); // RULE8
    assign day_bound = rtc_minute_tick_i && rtc_minute_i == 6'h00
                       && rtc_hour_i == hour_q; // RULE7
    // A setting of zero days stops maximum reports; max_q still follows the samples.
    assign max_bound = day_bound && days_q != 9'h000
                       && day_cnt_q + 9'h001 >= days_q; // RULE5
    assign avg_fire  = avg_bound && avg_run_q; // RULE3
    assign max_fire  = max_bound && max_run_q; // RULE6

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            avg_run_q <= 1'b0;
        end else if (avg_sel_q == AVGMX_WIN_OFF) begin
            avg_run_q <= 1'b0; // RULE2
        end else if (avg_bound) begin
            avg_run_q <= 1'b1; // RULE8
        end
    end

    // The window that ends at a boundary excludes that cycle's sample;
    // the sample opens the next window instead.
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sum_q   <= '0;
            count_q <= '0;
        end else if (avg_bound || stats_clear_input_i
                     || avg_sel_q == AVGMX_WIN_OFF) begin
            sum_q   <= sample_valid_i && avg_sel_q != AVGMX_WIN_OFF
                       && !stats_clear_input_i
                       ? SUM_W'(sample_i) : '0; // RULE9
            count_q <= sample_valid_i && avg_sel_q != AVGMX_WIN_OFF
                       && !stats_clear_input_i
                       ? COUNT_W'(1) : '0;
        end else if (sample_valid_i && count_q != '1) begin
            sum_q   <= sum_q + SUM_W'(sample_i); // RULE11
            count_q <= count_q + COUNT_W'(1);
        end
    end

    // A window with no samples reports zero rather than dividing by it.
    assign mean = count_q == '0 ? '0
                  : sum_q / SUM_W'(count_q); // RULE11

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            scada_avg_o       <= '0;
            scada_avg_valid_o <= 1'b0;
            log_avg_valid_o   <= 1'b0;
        end else begin
            scada_avg_valid_o <= avg_fire; // RULE3
            log_avg_valid_o   <= avg_fire && average_log_enable_i; // RULE4
            if (avg_fire) begin
                scada_avg_o <= mean[SAMPLE_W-1:0]; // RULE1
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            max_run_q <= 1'b0;
            day_cnt_q <= 9'h000;
        end else if (days_q == 9'h000) begin
            max_run_q <= 1'b0;
            day_cnt_q <= 9'h000;
        end else if (day_bound) begin
            max_run_q <= 1'b1; // RULE8
            day_cnt_q <= max_bound ? 9'h000 : day_cnt_q + 9'h001;
        end
    end

    // Unsigned maximum; zero is the empty value after any clear.
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            max_q <= '0;
        end else if (max_bound || stats_clear_input_i) begin // RULE9
            max_q <= sample_valid_i && !stats_clear_input_i
                     ? sample_i : '0; // RULE11
        end else if (sample_valid_i && sample_i > max_q) begin
            max_q <= sample_i; // RULE1
        end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            scada_max_o       <= '0;
            scada_max_valid_o <= 1'b0;
            log_max_valid_o   <= 1'b0;
        end else begin
            scada_max_valid_o <= max_fire; // RULE6
            log_max_valid_o   <= max_fire; // RULE6
            if (max_fire) begin
                scada_max_o <= max_q; // RULE9
            end
        end
    end

    // Checks guarding the behaviour above.
    sequence s_avg_fire;
        avg_bound && avg_run_q;
    endsequence

    sequence s_avg_report;
        scada_avg_valid_o ##1 !scada_avg_valid_o;
    endsequence

    a_avg_off_quiet: assert property (@(posedge ref_clk_i) // RULE2
        disable iff (!arst_n_i)
        avg_sel_q == AVGMX_WIN_OFF ##1 avg_sel_q == AVGMX_WIN_OFF
        |-> !scada_avg_valid_o)
        else $error("average reported while averaging is off");

    a_avg_report_edge: assert property (@(posedge ref_clk_i) // RULE3
        disable iff (!arst_n_i)
        s_avg_fire |-> ##1 s_avg_report)
        else $error("average report not one pulse after expiry");

    a_avg_log_gate: assert property (@(posedge ref_clk_i) // RULE4
        disable iff (!arst_n_i)
        log_avg_valid_o == (scada_avg_valid_o
                            && $past(average_log_enable_i)))
        else $error("average log does not follow enable");

    a_days_range: assert property (@(posedge ref_clk_i) // RULE5
        disable iff (!arst_n_i)
        days_q <= `AVGMX_MAX_DAYS)
        else $error("maximum window beyond limit");

    a_max_log_always: assert property (@(posedge ref_clk_i) // RULE6
        disable iff (!arst_n_i)
        scada_max_valid_o |-> log_max_valid_o
            && scada_max_o == $past(max_q))
        else $error("maximum report not logged with its value");

    a_hour_match: assert property (@(posedge ref_clk_i) // RULE7
        disable iff (!arst_n_i)
        scada_max_valid_o |-> $past(rtc_hour_i) == $past(hour_q)
            && $past(rtc_minute_i) == 6'h00 && hour_q <= 5'h17)
        else $error("maximum reported off its hour");

    a_avg_on_clock: assert property (@(posedge ref_clk_i) // RULE8
        disable iff (!arst_n_i)
        $rose(avg_run_q) |-> $past(rtc_minute_tick_i))
        else $error("average window opened off a clock boundary");

    a_clear_empties: assert property (@(posedge ref_clk_i) // RULE9
        disable iff (!arst_n_i)
        stats_clear_input_i |=> count_q == '0 && max_q == '0)
        else $error("clear did not empty the results");

    a_max_tracks: assert property (@(posedge ref_clk_i) // RULE11
        disable iff (!arst_n_i)
        sample_valid_i && !stats_clear_input_i && !max_bound
            && sample_i > max_q |=> max_q == $past(sample_i))
        else $error("maximum missed a larger sample");

    a_wb_ack_pulse: assert property (@(posedge ref_clk_i)
        disable iff (!arst_n_i)
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus answer is not a single-cycle ack");

    a_irq_level: assert property (@(posedge ref_clk_i)
        disable iff (!arst_n_i)
        $rose(scada_avg_valid_o) && mask_q[0] |-> ##1 irq_o)
        else $error("unmasked report raised no interrupt");

endmodule : avgmx_tracker

`default_nettype wire

/* tb/avgmx_sink.sv */
// Far-side model: the supervisory channel and the local event log.
// Assumes report strobes are one-cycle pulses sampled on clk_i.
`timescale 1ns/1ps
`default_nettype none

module avgmx_sink (
    input  wire logic        clk_i,
    input  wire logic        arst_n_i,
    input  wire logic [15:0] avg_i,
    input  wire logic        avg_vld_i,
    input  wire logic        log_avg_i,
    input  wire logic [15:0] max_i,
    input  wire logic        max_vld_i,
    input  wire logic        log_max_i,
    output logic      [15:0] avg_o,
    output logic      [15:0] max_o,
    output logic      [7:0]  n_avg_o,
    output logic      [7:0]  n_lavg_o,
    output logic      [7:0]  n_max_o,
    output logic      [7:0]  n_lmax_o
);
    // Each strobe is one report, so values are latched on the strobe only.
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            {avg_o, max_o} <= '0;
            {n_avg_o, n_lavg_o, n_max_o, n_lmax_o} <= '0;
        end else begin
            if (avg_vld_i) begin
                avg_o   <= avg_i;
                n_avg_o <= n_avg_o + 8'h01;
            end
            if (log_avg_i) n_lavg_o <= n_lavg_o + 8'h01;
            if (max_vld_i) begin
                max_o   <= max_i;
                n_max_o <= n_max_o + 8'h01;
            end
            if (log_max_i) n_lmax_o <= n_lmax_o + 8'h01;
        end
    end
endmodule : avgmx_sink
`default_nettype wire

/* tb/test_average_maximum_tracker.sv */
// Bench for the tracker: bus set-up, windows, logging, clear, interrupt.
// Assumes the design, its package and header on the include path.
`timescale 1ns/1ps
`include "avgmx_defs.svh"
`default_nettype none

module test_average_maximum_tracker;
    import avgmx_pkg::*;
    logic clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, ack, irq;
    logic vld = 0, clr = 0, en = 0, tick = 0;
    logic av, lav, mv, lmv;
    logic [7:0] adr = '0;
    logic [31:0] wdat = '0, rdat, d;
    logic [15:0] smp = '0, avg, mx, a_q, m_q;
    logic [7:0] na, nla, nm, nlm;
    avgmx_min_t mn = '0;
    avgmx_hour_t hr = '0;
    int n_fail = 0, compares = 0;

    always #4 clk = ~clk;

    avgmx_tracker u_avgmx_tracker (.ref_clk_i(clk), .arst_n_i(rst_n),
        .sample_i(smp), .sample_valid_i(vld), .stats_clear_input_i(clr),
        .average_log_enable_i(en), .rtc_minute_i(mn), .rtc_hour_i(hr),
        .rtc_minute_tick_i(tick), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .scada_avg_o(avg),
        .scada_avg_valid_o(av), .log_avg_valid_o(lav), .scada_max_o(mx),
        .scada_max_valid_o(mv), .log_max_valid_o(lmv), .irq_o(irq));

    avgmx_sink u_avgmx_sink (.clk_i(clk), .arst_n_i(rst_n), .avg_i(avg),
        .avg_vld_i(av), .log_avg_i(lav), .max_i(mx), .max_vld_i(mv),
        .log_max_i(lmv), .avg_o(a_q), .max_o(m_q), .n_avg_o(na),
        .n_lavg_o(nla), .n_max_o(nm), .n_lmax_o(nlm));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Registered outputs read right after an edge show their sampled value.
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] v);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= v;
        // Only the watchdog ends a wait for an answer that never comes.
        @(posedge clk);
        while (ack !== 1'b1) @(posedge clk);
        d = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask : bus

    task automatic tk(input int m, input int h);
        @(posedge clk);
        tick <= 1'b1;
        mn <= avgmx_min_t'(m);
        hr <= avgmx_hour_t'(h);
        @(posedge clk);
        tick <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : tk

    task automatic samp(input logic [15:0] v);
        @(posedge clk);
        smp <= v;
        vld <= 1'b1;
        @(posedge clk);
        vld <= 1'b0;
    endtask : samp

    task automatic t_defaults;
        bus(0, `AVGMX_OFF_AVG_CFG, 0); chk(d, 32'h0);
        bus(0, `AVGMX_OFF_MAX_CFG, 0); chk(d, 32'h000c0001);
        bus(0, 8'h1c, 0); chk(d, 32'h0);
        bus(1, `AVGMX_OFF_MAX_CFG, 32'h00180001);
        bus(0, `AVGMX_OFF_MAX_CFG, 0); chk(d, 32'h000c0001);
    endtask : t_defaults

    task automatic t_average;
        bus(1, `AVGMX_OFF_AVG_CFG, 32'h1);
        bus(1, `AVGMX_OFF_MASK, 32'h3);
        tk(0, 0);
        chk(na, 8'h0);
        samp(16'h000a); samp(16'h0014); samp(16'h0021);
        tk(3, 0);
        chk(na, 8'h0);
        tk(5, 0);
        chk(na, 8'h1);
        chk(a_q, 16'h0015);
        chk(nla, 8'h0);
        chk(irq, 1'b1);
        bus(1, `AVGMX_OFF_MASK, 32'h0);
        chk(irq, 1'b0);
        bus(1, `AVGMX_OFF_MASK, 32'h3);
        bus(0, `AVGMX_OFF_STATUS, 0); chk(d, 32'h1);
        bus(1, `AVGMX_OFF_STATUS, 32'h1);
        chk(irq, 1'b0);
        en <= 1'b1;
        samp(16'h0007);
        tk(10, 0);
        chk(a_q, 16'h0007);
        chk(nla, 8'h1);
    endtask : t_average

    task automatic t_clear;
        samp(16'h0064);
        @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        samp(16'h0004);
        tk(15, 0);
        chk(na, 8'h3);
        chk(a_q, 16'h0004);
        en <= 1'b0;
        bus(1, `AVGMX_OFF_AVG_CFG, 32'h0);
        tk(20, 0);
        chk(na, 8'h3);
        chk(nla, 8'h2);
    endtask : t_clear

    // Window lengths 10, 15, 30 and 60 minutes: no report mid-window, one at its boundary.
    task automatic t_windows;
        int sel [4] = '{2, 3, 4, 5};
        int mid [4] = '{5, 5, 15, 30};
        int fin [4] = '{10, 15, 30, 0};
        int i;
        for (i = 0; i < 4; i++) begin
            bus(1, `AVGMX_OFF_AVG_CFG, 32'(sel[i]));
            tk(0, 0);
            samp(16'(i + 1));
            tk(mid[i], 0);
            chk(na, 8'(3 + i));
            bus(0, `AVGMX_OFF_COUNT, 0); chk(d, 32'h1);
            tk(fin[i], 0);
            chk(na, 8'(4 + i));
            bus(0, `AVGMX_OFF_AVG_RES, 0); chk(d, 32'(i + 1));
            bus(1, `AVGMX_OFF_AVG_CFG, 32'h0);
        end
    endtask : t_windows

    task automatic t_max;
        bus(1, `AVGMX_OFF_MAX_CFG, 32'h00020001);
        tk(0, 2);
        samp(16'h0032); samp(16'h005a); samp(16'h001e);
        tk(0, 3);
        chk(nm, 8'h0);
        tk(0, 2);
        chk(nm, 8'h1);
        chk(m_q, 16'h005a);
        chk(nlm, 8'h1);
        bus(0, `AVGMX_OFF_MAX_RES, 0); chk(d, 32'h5a);
        samp(16'h0063);
        @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        samp(16'h0028);
        tk(0, 2);
        chk(m_q, 16'h0028);
        chk(nlm, 8'h2);
        chk(nla, 8'h2);
    endtask : t_max

    task automatic give_verdict;
        if (n_fail == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : give_verdict

    initial begin
        #20000;
        n_fail++;
        give_verdict();
    end

    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        t_defaults();
        t_average();
        t_clear();
        t_windows();
        t_max();
        give_verdict();
    end
endmodule : test_average_maximum_tracker
`default_nettype wire
